// file: design/irq_entry_seq.sv
/*
 * irq_entry_seq: masks maskable requests against the priority threshold and
 * runs the interrupt entry sequence with documented cycle counts.
 * Assumes request pulses come from logic on mclk and the pipeline reports
 * instruction boundaries and interruptible string instructions on mclk.
 */
//
// Contract
// - threshold n (0..6) enables levels above n; value 7 masks all maskable requests
// - ordinary instruction: priority judged at completion, sequence starts next cycle
// - string move/store and repeated multiply-accumulate are suspended for entry
// - first step reads address zero to fetch interrupt number and level
// - flag word before the sequence is copied to a hidden holding register
// - clear enable, trace, stack select; stack select kept for software 32-63
// - push held flag word first, then program counter
// - last step loads threshold with the accepted interrupt level
// - after the sequence, execution begins at the routine's first address
// - wait for instruction completion never exceeds thirty cycles
// - 16-bit bus: 18/19/20 cycles by vector and stack parity; 8-bit bus: 20
// - debugger break adds two cycles; address match or single-step adds one
// - watchdog sets threshold 7, reset sets 0, other unlevelled sources keep it
// - accept only with enable set, request bit set, level above threshold
// - level field 1..7 low to high, zero disables the source
// - request bit set by hardware, cleared on acceptance or by software
// - highest level wins; ties go to the lower source index
`timescale 1ns/1ps
module irq_entry_seq (
    input  wire logic                                        mclk,
    input  wire logic                                        rst_n,
    input  wire logic [irq_entry_pkg::NUM_SRC-1:0]           src_req,
    input  wire logic [irq_entry_pkg::NUM_SRC-1:0]           src_req_clr,
    input  wire logic [irq_entry_pkg::NUM_SRC*3-1:0]         src_level,
    input  wire irq_entry_pkg::special_req_t                 special_req,
    input  wire logic                                        insn_done,
    input  wire logic                                        insn_suspendable,
    input  wire logic                                        bus_8bit,
    input  wire logic                                        vector_odd,
    input  wire logic                                        stack_odd,
    input  wire logic [irq_entry_pkg::FLAG_W-1:0]            flag_wr_data,
    input  wire logic                                        flag_wr,
    input  wire logic [irq_entry_pkg::PC_W-1:0]              pc_in,
    input  wire logic [irq_entry_pkg::PC_W-1:0]              vector_target,
    output logic [irq_entry_pkg::NUM_SRC-1:0]                req_pending,
    output logic [irq_entry_pkg::FLAG_W-1:0]                 flag_word,
    output logic [2:0]                                       processor_priority_threshold,
    output logic                                             seq_busy,
    output logic                                             suspend_insn,
    output logic                                             read_zero,
    output logic [irq_entry_pkg::NUM_W-1:0]                  accepted_number,
    output logic [2:0]                                       accepted_level,
    output irq_entry_pkg::push_t                             push,
    output logic                                             fetch_start,
    output logic [irq_entry_pkg::PC_W-1:0]                   fetch_addr
);
    typedef enum logic [1:0] {ST_RUN, ST_SEQ} seq_state_t;

    seq_state_t                          state_q;
    logic [irq_entry_pkg::CNT_W-1:0]     cnt_q;
    logic [irq_entry_pkg::CNT_W-1:0]     len_q;
    logic [irq_entry_pkg::CNT_W-1:0]     len_d;
    logic [irq_entry_pkg::FLAG_W-1:0]    hold_q;
    irq_entry_pkg::src_kind_t            kind_q;
    logic [irq_entry_pkg::NUM_W-1:0]     num_q;
    logic [2:0]                          lvl_q;
    logic [irq_entry_pkg::NUM_SRC-1:0]   win_q;
    logic                                masked_hit;
    logic [2:0]                          best_lvl;
    logic [irq_entry_pkg::NUM_SRC-1:0]   best_oh;
    logic [irq_entry_pkg::NUM_W-1:0]     best_num;
    logic                                sample_pt;
    logic                                accept;

    // priority resolution: strict greater keeps the lowest index on a tie
    always_comb begin
        best_lvl = 3'h0;
        best_oh  = '0;
        best_num = '0;
        for (int i = 0; i < irq_entry_pkg::NUM_SRC; i++) begin
            // a zero field never beats best_lvl = 0, so it stays disabled
            if (req_pending[i] && (src_level[i*3 +: 3] > best_lvl)) begin
                best_lvl = src_level[i*3 +: 3];
                best_oh  = '0;
                best_oh[i] = 1'b1;
                best_num = irq_entry_pkg::NUM_W'(i);
            end
        end
    end

    // threshold 7 can never be exceeded by a 3-bit level, so all are masked
    assign masked_hit = flag_word[irq_entry_pkg::FLAG_IEN_BIT]
                        && (best_lvl > processor_priority_threshold);

    // sampling happens at an instruction boundary or inside a suspendable one
    assign sample_pt = insn_done || insn_suspendable;
    assign accept    = (state_q == ST_RUN) && sample_pt && (special_req.valid || masked_hit);
    assign suspend_insn = accept && insn_suspendable && !insn_done;

    // sequence length from bus width, parity and source kind
    always_comb begin
        if (bus_8bit) begin
            len_d = irq_entry_pkg::SEQ_WIDE_BUS;
        end else begin
            len_d = irq_entry_pkg::SEQ_BASE + {4'h0, vector_odd} + {4'h0, stack_odd};
        end
        if (special_req.valid && special_req.kind == irq_entry_pkg::SRC_DBG_BREAK) begin
            len_d = len_d + irq_entry_pkg::SEQ_ADD_DBG;
        end else if (special_req.valid && (special_req.kind == irq_entry_pkg::SRC_ADDR_MATCH
                     || special_req.kind == irq_entry_pkg::SRC_SINGLE_STEP)) begin
            len_d = len_d + irq_entry_pkg::SEQ_ADD_ONE;
        end
    end

    // request bits: a new request wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_pending <= '0;
        end else begin
            req_pending <= (req_pending & ~src_req_clr
                           & ~((state_q == ST_SEQ && cnt_q == irq_entry_pkg::STEP_READ0) ? win_q : '0))
                           | src_req;
        end
    end

    // state and step counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            cnt_q   <= '0;
            len_q   <= irq_entry_pkg::SEQ_BASE;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (accept) begin
                        state_q <= ST_SEQ; // entry begins next cycle
                        cnt_q   <= '0;
                        len_q   <= len_d;
                    end
                end
                ST_SEQ: begin
                    if (cnt_q == len_q - 5'h01) begin
                        state_q <= ST_RUN;
                    end
                    cnt_q <= cnt_q + 5'h01;
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // latch what was accepted; special requests outrank the maskable one
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            kind_q <= irq_entry_pkg::SRC_MASKABLE;
            num_q  <= '0;
            lvl_q  <= 3'h0;
            win_q  <= '0;
        end else if (accept) begin
            if (special_req.valid) begin
                kind_q <= special_req.kind;
                num_q  <= special_req.number;
                lvl_q  <= 3'h0;
                win_q  <= '0;
            end else begin
                kind_q <= irq_entry_pkg::SRC_MASKABLE;
                num_q  <= best_num;
                lvl_q  <= best_lvl;
                win_q  <= best_oh;
            end
        end
    end

    // step 0 read of address zero returns number and level
    assign read_zero = (state_q == ST_SEQ) && (cnt_q == irq_entry_pkg::STEP_READ0);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accepted_number <= '0;
            accepted_level  <= 3'h0;
        end else if (read_zero) begin
            accepted_number <= num_q;
            accepted_level  <= lvl_q;
        end
    end

    // hidden holding copy of the flag word, taken before anything is cleared
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= irq_entry_pkg::FLAG_RESET;
        end else if (state_q == ST_SEQ && cnt_q == irq_entry_pkg::STEP_HOLD) begin
            hold_q <= flag_word;
        end
    end

    // flag word and threshold; pipeline writes are ignored during the sequence
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_word <= irq_entry_pkg::FLAG_RESET;
            processor_priority_threshold <= irq_entry_pkg::THRESH_RESET;
        end else if (state_q == ST_SEQ) begin
            if (cnt_q == irq_entry_pkg::STEP_CLEAR) begin
                flag_word[irq_entry_pkg::FLAG_IEN_BIT]   <= 1'b0;
                flag_word[irq_entry_pkg::FLAG_TRACE_BIT] <= 1'b0;
                if (!(kind_q == irq_entry_pkg::SRC_SWI && num_q >= irq_entry_pkg::SWI_KEEP_LO
                      && num_q <= irq_entry_pkg::SWI_KEEP_HI)) begin
                    flag_word[irq_entry_pkg::FLAG_STACK_BIT] <= 1'b0;
                end
            end
            if (cnt_q == len_q - 5'h01) begin
                case (kind_q)
                    irq_entry_pkg::SRC_MASKABLE: processor_priority_threshold <= lvl_q;
                    irq_entry_pkg::SRC_WDT:   processor_priority_threshold <= irq_entry_pkg::THRESH_WDT;
                    irq_entry_pkg::SRC_RESET: processor_priority_threshold <= irq_entry_pkg::THRESH_RESET;
                    default: processor_priority_threshold <= processor_priority_threshold;
                endcase
            end
        end else if (flag_wr) begin
            flag_word <= flag_wr_data;
            processor_priority_threshold <= flag_wr_data[14:12];
        end
    end

    // stack pushes: held flag word first, program counter next
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            push <= '0;
        end else begin
            push.valid <= (state_q == ST_SEQ) && (cnt_q == irq_entry_pkg::STEP_PUSHF
                          || cnt_q == irq_entry_pkg::STEP_PUSHPC);
            push.is_pc <= (cnt_q == irq_entry_pkg::STEP_PUSHPC);
            push.data  <= (cnt_q == irq_entry_pkg::STEP_PUSHPC) ? pc_in
                          : {4'h0, hold_q};
        end
    end

    // start fetching at the routine once the last step retires
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_start <= 1'b0;
            fetch_addr  <= irq_entry_pkg::PC_RESET;
        end else begin
            fetch_start <= (state_q == ST_SEQ) && (cnt_q == len_q - 5'h01);
            if ((state_q == ST_SEQ) && (cnt_q == len_q - 5'h01)) begin
                fetch_addr <= vector_target;
            end
        end
    end

    assign seq_busy = (state_q == ST_SEQ);
endmodule : irq_entry_seq

// file: design/irq_entry_pkg.sv
/*
 * irq_entry_pkg: constants and carrier types for the interrupt entry sequencer.
 * Assumes one 25 MHz core clock; no register bus, all controls are ports.
 */
package irq_entry_pkg;
    localparam int unsigned NUM_SRC      = 8;     // peripheral request sources
    localparam int unsigned LVL_W        = 3;
    localparam int unsigned NUM_W        = 6;
    localparam int unsigned FLAG_W       = 16;
    localparam int unsigned PC_W         = 20;
    localparam int unsigned CNT_W        = 5;
    // flag word bit positions
    localparam int unsigned FLAG_TRACE_BIT  = 3;
    localparam int unsigned FLAG_IEN_BIT    = 6;
    localparam int unsigned FLAG_STACK_BIT  = 7;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;
    localparam logic [PC_W-1:0]   PC_RESET   = 20'h00000;
    // threshold values for sources without a programmable level, plus the mask-all value
    localparam logic [2:0] THRESH_WDT    = 3'h7;
    localparam logic [2:0] THRESH_RESET  = 3'h0;
    localparam logic [2:0] THRESH_MASKALL = 3'h7;
    // software interrupt numbers that keep the stack select flag
    localparam logic [NUM_W-1:0] SWI_KEEP_LO = 6'h20;
    localparam logic [NUM_W-1:0] SWI_KEEP_HI = 6'h3F;
    // entry sequence lengths in cycles
    localparam logic [CNT_W-1:0] SEQ_BASE     = 5'h12;  // 18 cycles, both even
    localparam logic [CNT_W-1:0] SEQ_WIDE_BUS = 5'h14;  // 20 cycles, 8-bit bus
    localparam logic [CNT_W-1:0] SEQ_ADD_DBG  = 5'h02;
    localparam logic [CNT_W-1:0] SEQ_ADD_ONE  = 5'h01;
    localparam int unsigned MAX_INSN_CYCLES   = 30;     // long divide worst case
    // sequence step offsets within the count
    localparam logic [CNT_W-1:0] STEP_READ0  = 5'h00;
    localparam logic [CNT_W-1:0] STEP_HOLD   = 5'h01;
    localparam logic [CNT_W-1:0] STEP_CLEAR  = 5'h02;
    localparam logic [CNT_W-1:0] STEP_PUSHF  = 5'h03;
    localparam logic [CNT_W-1:0] STEP_PUSHPC = 5'h04;

    typedef enum logic [2:0] {
        SRC_MASKABLE,
        SRC_WDT,
        SRC_RESET,
        SRC_DBG_BREAK,
        SRC_ADDR_MATCH,
        SRC_SINGLE_STEP,
        SRC_SWI
    } src_kind_t;

    // special (non-maskable) entry request from the core
    typedef struct packed {
        logic             valid;
        src_kind_t        kind;
        logic [NUM_W-1:0] number;
    } special_req_t;

    // stack push presented to the memory side
    typedef struct packed {
        logic              valid;
        logic              is_pc;
        logic [PC_W-1:0]   data;
    } push_t;
endpackage : irq_entry_pkg

// file: verif/insn_pipe_model.sv
/*
 * insn_pipe_model: stand-in for the instruction pipeline that reports completions.
 * Assumes it shares mclk and rst_n with the sequencer.
 */
`timescale 1ns/1ps
module insn_pipe_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [4:0] insn_len,
    output logic            insn_done
);
    logic [4:0] cnt_q;
    logic       last;

    // an instruction never runs past the long divide worst case of 30 cycles
    assign last      = (cnt_q >= insn_len) || (cnt_q >= 5'h1E);
    assign insn_done = rst_n && last;

    // cycle counter within the current instruction
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'h01;
        end else if (last) begin
            cnt_q <= 5'h01;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule : insn_pipe_model

// file: verif/irq_entry_props.sv
/*
 * irq_entry_props: port-level assertions for the interrupt entry sequencer.
 * Assumes the single mclk domain with async active-low rst_n; bound below.
 */
`timescale 1ns/1ps
module irq_entry_props (
    input wire logic                             mclk,
    input wire logic                             rst_n,
    input wire irq_entry_pkg::special_req_t      special_req,
    input wire logic                             insn_done,
    input wire logic                             insn_suspendable,
    input wire logic                             bus_8bit,
    input wire logic                             vector_odd,
    input wire logic                             stack_odd,
    input wire logic [irq_entry_pkg::PC_W-1:0]   vector_target,
    input wire logic [irq_entry_pkg::FLAG_W-1:0] flag_word,
    input wire logic [2:0]                       processor_priority_threshold,
    input wire logic                             seq_busy,
    input wire logic                             suspend_insn,
    input wire logic                             read_zero,
    input wire logic [2:0]                       accepted_level,
    input wire irq_entry_pkg::push_t             push,
    input wire logic                             fetch_start,
    input wire logic [irq_entry_pkg::PC_W-1:0]   fetch_addr
);
    logic [4:0] len_d, len_q, cnt_q;
    logic       spec_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // expected length follows the inputs while idle, so it freezes at acceptance
    always_comb begin
        len_d = bus_8bit ? 5'h14 : 5'h12 + {4'h0, vector_odd} + {4'h0, stack_odd};
        if (special_req.valid && special_req.kind == irq_entry_pkg::SRC_DBG_BREAK) len_d = len_d + 5'h02;
        if (special_req.valid && (special_req.kind == irq_entry_pkg::SRC_ADDR_MATCH ||
            special_req.kind == irq_entry_pkg::SRC_SINGLE_STEP)) len_d = len_d + 5'h01;
    end

    // busy cycle counter and acceptance snapshot
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            len_q  <= 5'h00;
            spec_q <= 1'b0;
            cnt_q  <= 5'h00;
        end else begin
            cnt_q <= seq_busy ? cnt_q + 5'h01 : 5'h00;
            if (!seq_busy) begin
                len_q  <= len_d;
                spec_q <= special_req.valid;
            end
        end
    end

    a_read_zero_first: assert property (read_zero == $rose(seq_busy))
        else $error("read of address zero not at sequence start");
    a_push_flag_pc: assert property (read_zero |-> ##4 (push.valid && !push.is_pc &&
        push.data == {4'h0, $past(flag_word, 5)}) ##1 (push.valid && push.is_pc))
        else $error("flag push then pc push out of place");
    a_flags_cleared: assert property (read_zero |-> ##3 !flag_word[6] && !flag_word[3])
        else $error("enable or trace flag not cleared");
    a_seq_length: assert property ($fell(seq_busy) |-> cnt_q == len_q)
        else $error("entry sequence length wrong");
    a_fetch_vector: assert property ($fell(seq_busy) |-> fetch_start && fetch_addr == $past(vector_target))
        else $error("routine fetch missing after sequence");
    a_level_loaded: assert property ($fell(seq_busy) && !spec_q |->
        processor_priority_threshold == accepted_level)
        else $error("threshold not loaded with accepted level");
    a_mask_all: assert property (!seq_busy && !special_req.valid && processor_priority_threshold == 3'h7
        |=> !read_zero) else $error("maskable accepted at threshold 7");
    a_enable_gate: assert property (!seq_busy && !special_req.valid && !flag_word[6] |=> !seq_busy)
        else $error("maskable accepted with enable clear");
    a_suspend_entry: assert property (!seq_busy && special_req.valid && insn_suspendable && !insn_done
        |-> suspend_insn ##1 read_zero) else $error("string instruction not suspended");
    a_entry_next: assert property (!seq_busy && special_req.valid && insn_done |=> read_zero)
        else $error("sequence did not start after completion");

    c_special: cover property ($fell(seq_busy) && spec_q);
    c_maskable: cover property ($fell(seq_busy) && !spec_q);
    c_suspend: cover property (suspend_insn);
endmodule : irq_entry_props

bind irq_entry_seq irq_entry_props irq_entry_props_inst (.mclk, .rst_n, .special_req, .insn_done,
    .insn_suspendable, .bus_8bit, .vector_odd, .stack_odd, .vector_target, .flag_word,
    .processor_priority_threshold, .seq_busy, .suspend_insn, .read_zero, .accepted_level, .push,
    .fetch_start, .fetch_addr);

// file: verif/tb.sv
/*
 * tb: self-checking bench for the interrupt entry sequencer and a pipeline stand-in.
 * Assumes a 25 MHz mclk; inputs change by non-blocking assignment at the rising edge.
 */
`timescale 1ns/1ps
module tb;
    logic                        mclk, rst_n, insn_suspendable, bus_8bit, vector_odd, stack_odd, flag_wr;
    logic                        insn_done, seq_busy, suspend_insn, read_zero, fetch_start;
    logic [7:0]                  src_req, src_req_clr, req_pending;
    logic [23:0]                 src_level;
    logic [15:0]                 flag_wr_data, flag_word;
    logic [19:0]                 pc_in, vector_target, fetch_addr;
    logic [5:0]                  accepted_number;
    logic [4:0]                  insn_len;
    logic [2:0]                  processor_priority_threshold, accepted_level;
    irq_entry_pkg::special_req_t special_req;
    irq_entry_pkg::push_t        push;
    int                          n_fail, n_checks, cyc, lat;
    bit                          sus;

    irq_entry_seq irq_entry_seq_inst (.mclk, .rst_n, .src_req, .src_req_clr, .src_level, .special_req,
        .insn_done, .insn_suspendable, .bus_8bit, .vector_odd, .stack_odd, .flag_wr_data, .flag_wr, .pc_in,
        .vector_target, .req_pending, .flag_word, .processor_priority_threshold, .seq_busy, .suspend_insn,
        .read_zero, .accepted_number, .accepted_level, .push, .fetch_start, .fetch_addr);
    insn_pipe_model insn_pipe_model_inst (.mclk, .rst_n, .insn_len, .insn_done);

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic wflag(input logic [15:0] d);
        @(posedge mclk);
        flag_wr_data <= d;
        flag_wr      <= 1'b1;
        @(posedge mclk);
        flag_wr      <= 1'b0;
    endtask : wflag

    // bounded wait for the start of a sequence; notes any suspension on the way
    // suspend_insn is combinational and only stands before the accepting edge, so look before each edge
    task automatic wait_rz;
        lat = 0;
        sus = 1'b0;
        #1;
        while (read_zero !== 1'b1 && lat < 40) begin
            if (suspend_insn === 1'b1) sus = 1'b1;
            @(posedge mclk);
            #1;
            lat++;
        end
    endtask : wait_rz

    // follows one sequence to its end, judging pushes on the way, then its length and the routine fetch
    task automatic run_seq(input logic [19:0] exp_flag, input int exp_len);
        int len;
        len = 0;
        while (seq_busy === 1'b1 && len < 40) begin
            if (push.valid === 1'b1) cmp(push.data, push.is_pc ? pc_in : exp_flag);
            @(posedge mclk);
            special_req.valid <= 1'b0;
            #1;
            len++;
        end
        if (exp_len > 0) cmp(len, exp_len);
        cmp({fetch_start, fetch_addr}, {1'b1, vector_target});
    endtask : run_seq

    task automatic t_special(input irq_entry_pkg::src_kind_t k, input logic [5:0] num, input logic [2:0] par,
                             input int exp_len);
        logic keep_u;
        keep_u = (k == irq_entry_pkg::SRC_SWI) && (num >= 6'h20);
        wflag(16'h3088); // threshold 3, stack select and trace set, enable off
        @(posedge mclk);
        {bus_8bit, vector_odd, stack_odd} <= par;
        special_req <= '{1'b1, k, num};
        wait_rz();
        run_seq(20'h03088, exp_len);
        cmp({flag_word[7], flag_word[6], flag_word[3]}, {keep_u, 2'h0});
        cmp(accepted_number, num);
        cmp(processor_priority_threshold, k == irq_entry_pkg::SRC_WDT ? 3'h7 :
            k == irq_entry_pkg::SRC_RESET ? 3'h0 : 3'h3);
    endtask : t_special

    task automatic t_mask;
        logic [2:0] lvl;
        for (int n = 0; n < 8; n++) begin
            lvl = (n == 7) ? 3'h7 : 3'(n + 1);
            wflag({1'b0, 3'(n), 12'h040});
            @(posedge mclk);
            src_level[2:0] <= lvl;
            src_req[0]     <= 1'b1;
            @(posedge mclk);
            src_req[0]     <= 1'b0;
            wait_rz();
            cmp(read_zero, n != 7);
            if (read_zero === 1'b1) begin
                run_seq({4'h0, 1'b0, 3'(n), 12'h040}, 18);
                cmp(processor_priority_threshold, lvl);
            end else begin
                @(posedge mclk);
                src_req_clr[0] <= 1'b1; // single-bit clear only
                @(posedge mclk);
                src_req_clr[0] <= 1'b0;
                #1;
            end
            cmp(req_pending[0], 1'b0);
        end
    endtask : t_mask

    task automatic t_prio;
        wflag(16'h0000); // enable off while the levels change
        @(posedge mclk);
        src_level <= 24'h02B140; // source 2 and 5 at level 5, source 4 at level 3
        src_req   <= 8'h34;
        @(posedge mclk);
        src_req   <= 8'h00;
        wflag(16'h0040); // enable only after the level change has landed
        wait_rz();
        run_seq(20'h00040, 18);
        cmp({accepted_number, accepted_level, req_pending}, {6'h02, 3'h5, 8'h30});
        @(posedge mclk);
        src_req_clr <= 8'hFF;
        @(posedge mclk);
        src_req_clr <= 8'h00;
    endtask : t_prio

    task automatic t_latency;
        @(posedge mclk);
        insn_len         <= 5'h1E;
        insn_suspendable <= 1'b1;
        t_special(irq_entry_pkg::SRC_SWI, 6'h02, 3'h0, 18);
        cmp({sus, lat <= 2}, 2'h3);
        insn_suspendable <= 1'b0;
        t_special(irq_entry_pkg::SRC_SWI, 6'h03, 3'h0, 18);
        cmp(lat <= 32, 1'b1);
        insn_len <= 5'h05;
    endtask : t_latency

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // runaway guard well above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("unexpected at %0t: run timed out", $time);
            test_done();
        end
    end

    initial begin
        {rst_n, insn_suspendable, bus_8bit, vector_odd, stack_odd, flag_wr} = 6'h00;
        {src_req, src_req_clr, src_level, flag_wr_data} = 56'h0;
        special_req   = '0;
        pc_in         = 20'h12344;
        vector_target = 20'h0ABC0; // even vector address by default
        insn_len      = 5'h05;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        cmp({processor_priority_threshold, flag_word, req_pending}, 27'h0);
        t_mask();
        t_prio();
        for (int i = 0; i < 8; i++) begin
            t_special(irq_entry_pkg::SRC_SWI, 6'h05, 3'(i), i[2] ? 20 : 18 + i[1] + i[0]);
        end
        t_special(irq_entry_pkg::SRC_DBG_BREAK, 6'h00, 3'h0, 20);
        t_special(irq_entry_pkg::SRC_ADDR_MATCH, 6'h00, 3'h0, 19);
        t_special(irq_entry_pkg::SRC_SINGLE_STEP, 6'h00, 3'h0, 19);
        t_special(irq_entry_pkg::SRC_WDT, 6'h00, 3'h0, 18);
        t_special(irq_entry_pkg::SRC_RESET, 6'h00, 3'h0, 18);
        t_special(irq_entry_pkg::SRC_SWI, 6'h28, 3'h0, 18);
        t_latency();
        test_done();
    end
endmodule : tb
